/* hw/ufc_pkg.sv */
// Constants, tables and shared types of the serial datapath core.
// Assumes one enabled core clock is one sampling clock of the bit timing.
// Behaviour
// - Non-FIFO: holding-empty sets on shift load.
// - Holding-empty interrupt only when enable bit 1.
// - Non-FIFO: transmitter-empty once shift register empties.
// - FIFO: 16 bytes; empty FIFO raises holding-empty.
// - FIFO: transmitter-empty when FIFO and shifter empty.
// - Start bit rechecked at half bit time.
// - Bits sampled mid-bit; errors in status 2-4.
// - Receive FIFO: 16 entries of 11 bits.
// - Holding read pops; status tags follow new head.
// - FIFO mode: holding register shows oldest character.
// - Receive interrupt per character or trigger level.
// - Timeout after four characters plus twelve bits.
// - Auto RTS needs feature bit and RTS asserted.
// - RTS rising edge sets flow interrupt bit.
// - Auto RTS goes high at next higher level.
// - Auto RTS returns low at next lower level.
// - Receiver keeps accepting until FIFO full.
// - Auto CTS stops transmitter after current character.
// - CTS going high sets flow interrupt bit.
// - Xoff match halts transmit after current character.
// - Xoff sets flag; Xon resumes and clears it.
// - Xon/Xoff registers reset zero; pairs matched.
// - Flow control characters never enter receive FIFO.
// - Send Xoff two characters after trigger; Xon later.
// - Line control selects five to eight data bits.
// - Holding write advances FIFO; LSB sent first.
package ufc_pkg;
	localparam int AW = 4;
	localparam int DW = 8;

	// ********************
	// Register offsets.
	// ********************
	localparam logic [3:0] A_HOLD = 4'h0, A_IER = 4'h1, A_ISR = 4'h2, A_LCR = 4'h3;
	localparam logic [3:0] A_MCR = 4'h4, A_LSR = 4'h5, A_EFR = 4'h6, A_DLD = 4'h7;
	localparam logic [3:0] A_XON1 = 4'h8, A_XON2 = 4'h9, A_XOFF1 = 4'hA, A_XOFF2 = 4'hB;

	// ********************
	// Field positions and values.
	// ********************
	localparam int IER_RX = 0, IER_THR = 1, IER_XOFF = 5, IER_RTS = 6, IER_CTS = 7;
	localparam logic [7:0] IER_ENH_MASK = 8'hF0;
	localparam int FCR_EN = 0, FCR_RXRST = 1, FCR_TXRST = 2, FCR_TRIG = 6;
	localparam logic [7:0] FCR_KEEP = 8'hC1;
	localparam int LCR_PEN = 3, LCR_EVEN = 4, MCR_RTS = 1, DLD_SMP = 4;
	localparam int EFR_RXS = 0, EFR_RXD = 1, EFR_TXS = 2, EFR_TXD = 3;
	localparam int EFR_ENH = 4, EFR_ARTS = 6, EFR_ACTS = 7;
	localparam logic [7:0] ISR_NONE = 8'h01, ISR_THR = 8'h02, ISR_RXRDY = 8'h04;
	localparam logic [7:0] ISR_TMO = 8'h0C, ISR_XOFF = 8'h10, ISR_FLOW = 8'h20;
	localparam logic [7:0] RST_XCH = 8'h00, FULL_MASK = 8'hFF;
	localparam logic LINE_IDLE = 1'b1;

	// ********************
	// FIFO depths and trigger tables.
	// ********************
	localparam logic [4:0] FIFO_DEPTH = 5'h10, NOFIFO_DEPTH = 5'h01;
	localparam logic [3:0][4:0] TRIG_LVL = {5'h0E, 5'h08, 5'h04, 5'h01};
	localparam logic [3:0][4:0] LVL_UP = {5'h0E, 5'h0E, 5'h08, 5'h04};
	localparam logic [3:0][4:0] LVL_DN = {5'h08, 5'h04, 5'h01, 5'h00};

	// ********************
	// Bit timing.
	// ********************
	localparam logic [3:0] SPB16_M1 = 4'hF, SPB8_M1 = 4'h7, SPB4_M1 = 4'h3;
	localparam logic [3:0] HALF16_M1 = 4'h7, HALF8_M1 = 4'h3, HALF4_M1 = 4'h1;
	localparam logic [2:0] SH16 = 3'h4, SH8 = 3'h3, SH4 = 3'h2;
	localparam logic [3:0] FRAME_BASE = 4'h7;
	localparam logic [2:0] LAST_BASE = 3'h4;
	localparam logic [9:0] TMO_CHARS = 10'h004, TMO_BITS = 10'h00C, XOFF_CHARS = 10'h002;

	typedef enum logic [2:0] {
		SER_IDLE = 3'b000,
		SER_START = 3'b001,
		SER_DATA = 3'b010,
		SER_PAR = 3'b011,
		SER_STOP = 3'b100
	} ufc_ser_t;
endpackage

/* hw/ufc_core.sv */
// Transmit and receive datapath with FIFOs and flow control.
// Assumes synchronous inputs and one sampling clock per enabled edge.
//
// Strobed register access and the register offsets are this design's own decisions.
module ufc_core (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [ufc_pkg::AW-1:0] reg_addr,
	input wire logic [ufc_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [ufc_pkg::DW-1:0] reg_rdata,
	input wire logic rx_in,
	input wire logic cts_n,
	output logic tx_out,
	output logic rts_n,
	output logic irq
);
	import ufc_pkg::*;

	// ********************
	// State.
	// ********************
	typedef struct packed {
		logic [7:0] int_enable_reg;
		logic [7:0] line_ctrl_reg;
		logic [7:0] modem_ctrl_reg;
		logic [7:0] enhanced_feature_reg;
		logic [7:0] divisor_fraction_reg;
		logic [7:0] fifo_ctrl_reg;
		logic [3:0][7:0] xch;
		logic [15:0][7:0] txm;
		logic [3:0] twp;
		logic [3:0] trp;
		logic [4:0] tcnt;
		logic [15:0][10:0] rxm;
		logic [3:0] rwp;
		logic [3:0] rrp;
		logic [4:0] rcnt;
		ufc_ser_t ts;
		logic [3:0] tsc;
		logic [2:0] tbi;
		logic [7:0] tx_shift_reg;
		logic tpar;
		logic send_xoff;
		logic send_xon;
		logic ctl_2nd;
		ufc_ser_t rs;
		logic [3:0] rsc;
		logic [2:0] rbi;
		logic [7:0] rx_shift_reg;
		logic rpe;
		logic rprev;
		logic [7:0] hold;
		logic hold_v;
		logic [10:0] pend;
		logic pend_v;
		logic sw_halt;
		logic oe;
		logic thr_int;
		logic flow_int;
		logic xoff_int;
		logic tmo;
		logic [9:0] tmo_cnt;
		logic [9:0] xd_cnt;
		logic xoff_sent;
		logic rts_off;
		logic cts_prev;
		logic [7:0] rdata;
		logic tx;
		logic rts_n;
		logic irq;
	} ufc_st_t;

	ufc_st_t st_r;
	ufc_st_t st_nxt;

	logic [1:0] smp;
	logic [1:0] tsel;
	logic [3:0] spb_m1;
	logic [3:0] half_m1;
	logic [3:0] fb;
	logic [2:0] sh;
	logic [2:0] last_bit;
	logic [4:0] cap;
	logic [4:0] trig;
	logic [4:0] lvl_up;
	logic [4:0] lvl_dn;
	logic [9:0] tmo_lim;
	logic [9:0] xd_lim;
	logic [7:0] msk;
	logic [7:0] isr_val;
	logic [7:0] lsr_val;
	logic [10:0] head;
	logic [3:0][7:0] xm;
	logic fifo_on;
	logic cts_halt;
	logic rx_rdy;
	logic rx_sw_on;

	// ********************
	// Derived settings.
	// ********************
	assign smp = st_r.divisor_fraction_reg[DLD_SMP+1:DLD_SMP];
	assign spb_m1 = (smp == 2'b00) ? SPB16_M1 : ((smp == 2'b01) ? SPB8_M1 : SPB4_M1);
	assign half_m1 = (smp == 2'b00) ? HALF16_M1 : ((smp == 2'b01) ? HALF8_M1 : HALF4_M1);
	assign sh = (smp == 2'b00) ? SH16 : ((smp == 2'b01) ? SH8 : SH4);
	assign fifo_on = st_r.fifo_ctrl_reg[FCR_EN];
	assign cap = fifo_on ? FIFO_DEPTH : NOFIFO_DEPTH;
	assign tsel = fifo_on ? st_r.fifo_ctrl_reg[FCR_TRIG+1:FCR_TRIG] : 2'b00;
	assign trig = TRIG_LVL[tsel];
	assign lvl_up = LVL_UP[tsel];
	assign lvl_dn = LVL_DN[tsel];
	assign fb = FRAME_BASE + {2'b00, st_r.line_ctrl_reg[1:0]} + {3'b000, st_r.line_ctrl_reg[LCR_PEN]};
	assign last_bit = LAST_BASE + {1'b0, st_r.line_ctrl_reg[1:0]};
	assign msk = FULL_MASK >> ~st_r.line_ctrl_reg[1:0];
	assign tmo_lim = 10'((({7'h00, last_bit} + 10'h001) * TMO_CHARS + TMO_BITS)
		<< sh);
	assign xd_lim = 10'((10'(fb) * XOFF_CHARS) << sh);
	assign head = st_r.rxm[st_r.rrp];
	assign cts_halt = st_r.enhanced_feature_reg[EFR_ACTS] & cts_n;
	assign rx_sw_on = st_r.enhanced_feature_reg[EFR_RXS] | st_r.enhanced_feature_reg[EFR_RXD];
	assign rx_rdy = fifo_on ? (st_r.rcnt >= trig) : (st_r.rcnt != 5'h00);

	for (genvar i = 0; i < 4; i++) begin : g_msk
		assign xm[i] = st_r.xch[i] & msk;
	end

	assign isr_val = (st_r.tmo & st_r.int_enable_reg[IER_RX]) ? ISR_TMO :
		(rx_rdy & st_r.int_enable_reg[IER_RX]) ? ISR_RXRDY :
		(st_r.thr_int & st_r.int_enable_reg[IER_THR]) ? ISR_THR :
		st_r.xoff_int ? ISR_XOFF :
		st_r.flow_int ? ISR_FLOW : ISR_NONE;

	// Tags of the head entry appear in bits 2 to 4.
	assign lsr_val = {1'b0,
		(st_r.tcnt == 5'h00) & (st_r.ts == SER_IDLE),
		st_r.tcnt == 5'h00,
		(st_r.rcnt != 5'h00) ? head[10:8] : 3'b000,
		st_r.oe,
		st_r.rcnt != 5'h00};

	// ********************
	// Next state.
	// ********************
	always_comb begin
		logic tpush;
		logic tpop;
		logic tgo;
		logic rpush;
		logic rpop;
		logic rdone;
		logic clean;
		logic xoffm;
		logic xonm;
		logic [7:0] c;
		logic [10:0] rword;
		logic [10:0] pword;
		tpush = 1'b0;
		tpop = 1'b0;
		tgo = 1'b0;
		rpush = 1'b0;
		rpop = 1'b0;
		rdone = 1'b0;
		xoffm = 1'b0;
		xonm = 1'b0;
		pword = 11'h000;
		rword = {~rx_in & (st_r.rx_shift_reg == 8'h00), ~rx_in, st_r.rpe, st_r.rx_shift_reg};
		clean = ~(|rword[10:8]);
		c = st_r.rx_shift_reg & msk;
		st_nxt = st_r;
		st_nxt.rdata = 8'h00;
		st_nxt.rprev = rx_in;
		st_nxt.cts_prev = cts_n;

		// Register writes.
		if (reg_wr) begin
			case (reg_addr)
				A_HOLD: begin
					st_nxt.thr_int = 1'b0;
					if (st_r.tcnt < cap) begin
						tpush = 1'b1;
						st_nxt.txm[st_r.twp] = reg_wdata;
						st_nxt.twp = st_r.twp + 4'h1;
					end
				end
				A_IER: begin
					if (st_r.enhanced_feature_reg[EFR_ENH]) begin
						st_nxt.int_enable_reg = reg_wdata;
					end else begin
						st_nxt.int_enable_reg = (st_r.int_enable_reg & IER_ENH_MASK) | (reg_wdata & ~IER_ENH_MASK);
					end
				end
				A_ISR: st_nxt.fifo_ctrl_reg = reg_wdata & FCR_KEEP;
				A_LCR: st_nxt.line_ctrl_reg = reg_wdata;
				A_MCR: st_nxt.modem_ctrl_reg = reg_wdata;
				A_EFR: st_nxt.enhanced_feature_reg = reg_wdata;
				A_DLD: st_nxt.divisor_fraction_reg = reg_wdata;
				A_XON1, A_XON2, A_XOFF1, A_XOFF2: st_nxt.xch[reg_addr[1:0]] = reg_wdata;
				default: ;
			endcase
		end

		// Register reads.
		if (reg_rd) begin
			case (reg_addr)
				A_HOLD: begin
					if (st_r.rcnt != 5'h00) begin
						st_nxt.rdata = head[7:0];
						rpop = 1'b1;
					end
					st_nxt.tmo = 1'b0;
					st_nxt.tmo_cnt = 10'h000;
				end
				A_IER: st_nxt.rdata = st_r.int_enable_reg;
				A_ISR: begin
					st_nxt.rdata = isr_val;
					if (isr_val == ISR_THR) begin
						st_nxt.thr_int = 1'b0;
					end
					if (isr_val == ISR_FLOW) begin
						st_nxt.flow_int = 1'b0;
					end
				end
				A_LCR: st_nxt.rdata = st_r.line_ctrl_reg;
				A_MCR: st_nxt.rdata = st_r.modem_ctrl_reg;
				A_LSR: begin
					st_nxt.rdata = lsr_val;
					st_nxt.oe = 1'b0;
				end
				A_EFR: st_nxt.rdata = st_r.enhanced_feature_reg;
				A_DLD: st_nxt.rdata = st_r.divisor_fraction_reg;
				A_XON1, A_XON2, A_XOFF1, A_XOFF2: st_nxt.rdata = st_r.xch[reg_addr[1:0]];
				default: st_nxt.rdata = 8'h00;
			endcase
		end

		// ********************
		// Transmitter.
		// ********************
		if (st_r.ts == SER_IDLE) begin
			if ((st_r.send_xoff | st_r.send_xon) & ~cts_halt) begin
				tgo = 1'b1;
				st_nxt.tx_shift_reg = st_r.xch[{st_r.send_xoff, st_r.ctl_2nd}];
				if (st_r.enhanced_feature_reg[EFR_TXD] & ~st_r.ctl_2nd) begin
					st_nxt.ctl_2nd = 1'b1;
				end else begin
					st_nxt.ctl_2nd = 1'b0;
					st_nxt.send_xoff = 1'b0;
					st_nxt.send_xon = 1'b0;
				end
			end else if ((st_r.tcnt != 5'h00) & ~cts_halt & ~st_r.sw_halt) begin
				tgo = 1'b1;
				tpop = 1'b1;
				st_nxt.tx_shift_reg = st_r.txm[st_r.trp];
				st_nxt.trp = st_r.trp + 4'h1;
			end
			if (tgo) begin
				st_nxt.ts = SER_START;
				st_nxt.tsc = 4'h0;
				st_nxt.tx = 1'b0;
			end
		end else if (st_r.tsc != spb_m1) begin
			st_nxt.tsc = st_r.tsc + 4'h1;
		end else begin
			st_nxt.tsc = 4'h0;
			unique case (st_r.ts)
				SER_START: begin
					st_nxt.ts = SER_DATA;
					st_nxt.tbi = 3'h0;
					st_nxt.tx = st_r.tx_shift_reg[0];
					st_nxt.tpar = st_r.tx_shift_reg[0];
				end
				SER_DATA: begin
					if (st_r.tbi == last_bit) begin
						if (st_r.line_ctrl_reg[LCR_PEN]) begin
							st_nxt.ts = SER_PAR;
							st_nxt.tx = st_r.tpar ^ ~st_r.line_ctrl_reg[LCR_EVEN];
						end else begin
							st_nxt.ts = SER_STOP;
							st_nxt.tx = LINE_IDLE;
						end
					end else begin
						st_nxt.tbi = st_r.tbi + 3'h1;
						st_nxt.tx_shift_reg = st_r.tx_shift_reg >> 1;
						st_nxt.tx = st_r.tx_shift_reg[1];
						st_nxt.tpar = st_r.tpar ^ st_r.tx_shift_reg[1];
					end
				end
				SER_PAR: begin
					st_nxt.ts = SER_STOP;
					st_nxt.tx = LINE_IDLE;
				end
				SER_STOP: st_nxt.ts = SER_IDLE;
				default: st_nxt.ts = SER_IDLE;
			endcase
		end

		// ********************
		// Receiver.
		// ********************
		unique case (st_r.rs)
			SER_IDLE: begin
				if (st_r.rprev & ~rx_in) begin
					st_nxt.rs = SER_START;
					st_nxt.rsc = 4'h0;
				end
			end
			SER_START: begin
				if (st_r.rsc == half_m1) begin
					st_nxt.rsc = 4'h0;
					if (~rx_in) begin
						st_nxt.rs = SER_DATA;
						st_nxt.rbi = 3'h0;
						st_nxt.rx_shift_reg = 8'h00;
						st_nxt.rpe = 1'b0;
					end else begin
						st_nxt.rs = SER_IDLE;
					end
				end else begin
					st_nxt.rsc = st_r.rsc + 4'h1;
				end
			end
			SER_DATA, SER_PAR, SER_STOP: begin
				if (st_r.rsc != spb_m1) begin
					st_nxt.rsc = st_r.rsc + 4'h1;
				end else begin
					st_nxt.rsc = 4'h0;
					if (st_r.rs == SER_DATA) begin
						st_nxt.rx_shift_reg[st_r.rbi] = rx_in;
						st_nxt.rpe = st_r.rpe ^ rx_in;
						st_nxt.rbi = st_r.rbi + 3'h1;
						if (st_r.rbi == last_bit) begin
							st_nxt.rs = st_r.line_ctrl_reg[LCR_PEN] ? SER_PAR : SER_STOP;
							if (~st_r.line_ctrl_reg[LCR_PEN]) begin
								st_nxt.rpe = 1'b0;
							end
						end
					end else if (st_r.rs == SER_PAR) begin
						st_nxt.rpe = st_r.rpe ^ rx_in ^ ~st_r.line_ctrl_reg[LCR_EVEN];
						st_nxt.rs = SER_STOP;
					end else begin
						rdone = 1'b1;
						st_nxt.rs = SER_IDLE;
					end
				end
			end
			default: st_nxt.rs = SER_IDLE;
		endcase

		// ********************
		// Flow control character filter.
		// ********************
		if (rdone) begin
			st_nxt.tmo = 1'b0;
			st_nxt.tmo_cnt = 10'h000;
			if (~rx_sw_on) begin
				rpush = 1'b1;
				pword = rword;
			end else if (~st_r.enhanced_feature_reg[EFR_RXD]) begin
				if (clean & (c == xm[2])) begin
					xoffm = 1'b1;
				end else if (clean & (c == xm[0])) begin
					xonm = 1'b1;
				end else begin
					rpush = 1'b1;
					pword = rword;
				end
			end else if (st_r.hold_v) begin
				st_nxt.hold_v = 1'b0;
				if (clean & (st_r.hold == xm[2]) & (c == xm[3])) begin
					xoffm = 1'b1;
				end else if (clean & (st_r.hold == xm[0]) & (c == xm[1])) begin
					xonm = 1'b1;
				end else begin
					rpush = 1'b1;
					pword = {3'b000, st_r.hold};
					if (clean & ((c == xm[2]) | (c == xm[0]))) begin
						st_nxt.hold = c;
						st_nxt.hold_v = 1'b1;
					end else begin
						st_nxt.pend = rword;
						st_nxt.pend_v = 1'b1;
					end
				end
			end else if (clean & ((c == xm[2]) | (c == xm[0]))) begin
				st_nxt.hold = c;
				st_nxt.hold_v = 1'b1;
			end else begin
				rpush = 1'b1;
				pword = rword;
			end
		end else if (st_r.pend_v) begin
			rpush = 1'b1;
			pword = st_r.pend;
			st_nxt.pend_v = 1'b0;
		end
		if (xoffm) begin
			st_nxt.sw_halt = 1'b1;
			if (st_r.int_enable_reg[IER_XOFF]) begin
				st_nxt.xoff_int = 1'b1;
			end
		end
		if (xonm) begin
			st_nxt.sw_halt = 1'b0;
			st_nxt.xoff_int = 1'b0;
		end
		if (~rx_sw_on) begin
			st_nxt.sw_halt = 1'b0;
			st_nxt.hold_v = 1'b0;
		end

		// ********************
		// FIFO pointers and counts.
		// ********************
		if (rpush) begin
			if (st_r.rcnt < cap) begin
				st_nxt.rxm[st_r.rwp] = pword;
				st_nxt.rwp = st_r.rwp + 4'h1;
			end else begin
				rpush = 1'b0;
				st_nxt.oe = 1'b1;
			end
		end
		if (rpop) begin
			st_nxt.rrp = st_r.rrp + 4'h1;
		end
		st_nxt.rcnt = st_r.rcnt + 5'(rpush) - 5'(rpop);
		st_nxt.tcnt = st_r.tcnt + 5'(tpush) - 5'(tpop);
		if (tpop & (st_r.tcnt == 5'h01) & ~tpush) begin
			st_nxt.thr_int = 1'b1;
		end
		if (reg_wr & (reg_addr == A_ISR)) begin
			if (reg_wdata[FCR_RXRST]) begin
				st_nxt.rwp = 4'h0;
				st_nxt.rrp = 4'h0;
				st_nxt.rcnt = 5'h00;
			end
			if (reg_wdata[FCR_TXRST]) begin
				st_nxt.twp = 4'h0;
				st_nxt.trp = 4'h0;
				st_nxt.tcnt = 5'h00;
			end
		end

		// ********************
		// Receive timeout.
		// ********************
		if (st_r.rcnt == 5'h00) begin
			st_nxt.tmo = 1'b0;
			st_nxt.tmo_cnt = 10'h000;
		end else if (~rdone & ~rpop & ~st_r.tmo) begin
			if (st_r.tmo_cnt == tmo_lim - 10'h001) begin
				st_nxt.tmo = 1'b1;
			end else begin
				st_nxt.tmo_cnt = st_r.tmo_cnt + 10'h001;
			end
		end

		// ********************
		// Hardware flow control.
		// ********************
		if (~(st_r.enhanced_feature_reg[EFR_ARTS] & st_r.modem_ctrl_reg[MCR_RTS])) begin
			st_nxt.rts_off = 1'b0;
		end else if (st_r.rcnt >= lvl_up) begin
			st_nxt.rts_off = 1'b1;
		end else if (st_r.rcnt <= lvl_dn) begin
			st_nxt.rts_off = 1'b0;
		end
		st_nxt.rts_n = ~st_nxt.modem_ctrl_reg[MCR_RTS] | (st_nxt.enhanced_feature_reg[EFR_ARTS] & st_nxt.rts_off);
		if (st_r.int_enable_reg[IER_RTS] & ~st_r.rts_n & st_nxt.rts_n) begin
			st_nxt.flow_int = 1'b1;
		end
		if (st_r.int_enable_reg[IER_CTS] & ~st_r.cts_prev & cts_n) begin
			st_nxt.flow_int = 1'b1;
		end

		// ********************
		// Xoff and Xon sending.
		// ********************
		if (~st_r.enhanced_feature_reg[EFR_TXS] & ~st_r.enhanced_feature_reg[EFR_TXD]) begin
			st_nxt.xoff_sent = 1'b0;
			st_nxt.xd_cnt = 10'h000;
			st_nxt.send_xoff = 1'b0;
			st_nxt.send_xon = 1'b0;
			st_nxt.ctl_2nd = 1'b0;
		end else if (~st_r.xoff_sent) begin
			if (st_r.rcnt >= trig) begin
				if (st_r.xd_cnt == xd_lim - 10'h001) begin
					st_nxt.send_xoff = 1'b1;
					st_nxt.send_xon = 1'b0;
					st_nxt.ctl_2nd = 1'b0;
					st_nxt.xoff_sent = 1'b1;
					st_nxt.xd_cnt = 10'h000;
				end else begin
					st_nxt.xd_cnt = st_r.xd_cnt + 10'h001;
				end
			end else begin
				st_nxt.xd_cnt = 10'h000;
			end
		end else if (st_r.rcnt <= lvl_dn) begin
			st_nxt.send_xon = 1'b1;
			st_nxt.send_xoff = 1'b0;
			st_nxt.ctl_2nd = 1'b0;
			st_nxt.xoff_sent = 1'b0;
		end

		st_nxt.irq = (isr_val != ISR_NONE);
	end

	// ********************
	// Registers.
	// ********************
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_r <= '0;
			st_r.xch <= {4{RST_XCH}};
			st_r.tx <= LINE_IDLE;
			st_r.rts_n <= LINE_IDLE;
			st_r.rprev <= LINE_IDLE;
			st_r.cts_prev <= LINE_IDLE;
		end else if (clk_en) begin
			st_r <= st_nxt;
		end
	end

	assign reg_rdata = st_r.rdata;
	assign tx_out = st_r.tx;
	assign rts_n = st_r.rts_n;
	assign irq = st_r.irq;
endmodule

/* testbench/ufc_core_sva.sv */
// Port checker of the serial datapath core.
// Assumes it is bound into the core, clk_en held high and 16X sampling.
module ufc_core_sva (
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	input wire logic [ufc_pkg::AW-1:0] reg_addr,
	input wire logic [ufc_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [ufc_pkg::DW-1:0] reg_rdata,
	input wire logic rx_in,
	input wire logic cts_n,
	input wire logic tx_out,
	input wire logic rts_n,
	input wire logic irq
);
	import ufc_pkg::*;
	// ****
	// Shadow copies of control registers and a CTS-high cycle count.
	// ****
	logic [7:0] efr_r, ier_r, mcr_r, cts_cnt_r;
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			efr_r <= 8'h00;
			ier_r <= 8'h00;
			mcr_r <= 8'h00;
			cts_cnt_r <= 8'h00;
		end else if (clk_en) begin
			if (reg_wr && reg_addr == A_EFR) efr_r <= reg_wdata;
			if (reg_wr && reg_addr == A_MCR) mcr_r <= reg_wdata;
			if (reg_wr && reg_addr == A_IER)
				ier_r <= efr_r[EFR_ENH] ? reg_wdata : {ier_r[7:4], reg_wdata[3:0]};
			if (efr_r[EFR_ACTS] && cts_n) cts_cnt_r <= cts_cnt_r + 8'(cts_cnt_r != 8'hFF);
			else cts_cnt_r <= 8'h00;
		end
	end
	// ****
	// Assertions.
	// ****
	reset_out_a: assert property (@(posedge core_clk) disable iff (1'b0)
		!rst_n |=> tx_out && rts_n && !irq && reg_rdata == 8'h00) else $error("reset outputs");
	rdata_idle_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!reg_rd |=> reg_rdata == 8'h00) else $error("read data without read");
	unmapped_rd_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		reg_rd && reg_addr > A_XOFF2 |=> reg_rdata == 8'h00) else $error("unmapped read");
	start_bit_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$fell(tx_out) |-> !tx_out [*8] ##1 !tx_out [*8]) else $error("short low bit");
	cts_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		cts_cnt_r == 8'hFF |-> tx_out) else $error("sending while stopped");
	rts_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(rts_n) && ier_r[IER_RTS] |-> ##[0:3] irq) else $error("no flow interrupt");
	cts_irq_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		$rose(cts_n) && ier_r[IER_CTS] |-> ##[0:6] irq) else $error("no clear interrupt");
	irq_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		ier_r == 8'h00 && $past(ier_r) == 8'h00 |=> !irq) else $error("masked interrupt");
	rts_manual_a: assert property (@(posedge core_clk) disable iff (!rst_n)
		!efr_r[EFR_ARTS] && !$past(efr_r[EFR_ARTS]) && mcr_r[MCR_RTS] |-> !$rose(rts_n))
		else $error("request line rose");
endmodule

bind ufc_core ufc_core_sva i_ufc_core_sva (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .rx_in(rx_in), .cts_n(cts_n), .tx_out(tx_out), .rts_n(rts_n),
	.irq(irq));

/* testbench/ufc_remote.sv */
// Remote serial partner: sends frames into the core and collects its output.
// Assumes 8 data bits, no parity, one stop bit, 16 core clocks per bit.
module ufc_remote (
	input wire logic core_clk,
	input wire logic tx_line,
	input wire logic rts_n,
	output logic rx_line
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] got_q[$];
	logic [7:0] b;
	initial rx_line = 1'b1;
	task automatic send(input logic [7:0] d, input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		while (rts_n)
			@(posedge core_clk);
		for (int i = 0; i < 10; i++) begin
			rx_line <= f[i];
			repeat (16) @(posedge core_clk);
		end
		rx_line <= 1'b1;
		repeat (16) @(posedge core_clk);
	endtask
	task automatic glitch(input int n);
		rx_line <= 1'b0;
		repeat (n) @(posedge core_clk);
		rx_line <= 1'b1;
	endtask
	always begin
		@(negedge tx_line);
		repeat (8) @(posedge core_clk);
		for (int i = 0; i < 8; i++) begin
			repeat (16) @(posedge core_clk);
			b[i] = tx_line;
		end
		repeat (16) @(posedge core_clk);
		got_q.push_back(b);
	end
endmodule

/* testbench/ufc_core_bench.sv */
// Self-checking bench of the serial datapath core.
// Assumes the remote partner on the serial pins and 16X sampling.
module ufc_core_bench;
	timeunit 1ns;
	timeprecision 1ns;
	import ufc_pkg::*;
	logic core_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic cts_n = 1'b0, rx_in, tx_out, rts_n, irq;
	logic [3:0] reg_addr = 4'h0;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
	logic [7:0] sq[$];
	int fail_count = 0, n_checks = 0;
	always #25 core_clk = ~core_clk;
	ufc_core i_ufc_core (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .rx_in(rx_in), .cts_n(cts_n), .tx_out(tx_out),
		.rts_n(rts_n), .irq(irq));
	ufc_remote i_ufc_remote (.core_clk(core_clk), .tx_line(tx_out), .rts_n(rts_n),
		.rx_line(rx_in));
	// ****
	// Bus and checking tasks.
	// ****
	task automatic idle(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		idle(1);
		reg_wr <= 1'b0;
		idle(1);
	endtask
	task automatic rd(input logic [3:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		idle(1);
		reg_rd <= 1'b0;
		idle(1);
		d = reg_rdata;
	endtask
	task automatic pop_chk();
		rd(A_HOLD);
		chk(d, sq.pop_front());
	endtask
	task automatic put(input logic [7:0] v, input logic stop);
		sq.push_back(v);
		i_ufc_remote.send(v, stop);
	endtask
	task automatic wait_q(input int n);
		for (int i = 0; i < 5000 && i_ufc_remote.got_q.size() < n; i++) idle(1);
	endtask
	task automatic endt(input string s);
		$display("test %s done", s);
	endtask
	task automatic close_out();
		$display("checks=%0d mismatches=%0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		idle(40000);
		fail_count++;
		close_out();
	end
	// ****
	// Tests.
	// ****
	initial begin
		void'($urandom(32'h7c87));
		idle(3);
		rst_n <= 1'b1;
		idle(1);
		rd(A_LSR);
		chk(d, 8'h60);
		rd(4'hC);
		chk(d, 8'h00);
		rd(A_XOFF1);
		chk(d, RST_XCH);
		endt("reset");
		wr(A_LCR, 8'h03);
		wr(A_MCR, 8'h02);
		wr(A_IER, 8'h02);
		wr(A_ISR, 8'h01);
		for (int i = 0; i < 3; i++) begin
			sq.push_back(8'($urandom));
			wr(A_HOLD, sq[i]);
		end
		wait_q(3);
		for (int i = 0; i < 3; i++) chk(i_ufc_remote.got_q.pop_front(), sq.pop_front());
		idle(40);
		rd(A_LSR);
		chk(d & 8'h60, 8'h60);
		rd(A_ISR);
		chk(d, ISR_THR);
		rd(A_ISR);
		chk(d, ISR_NONE);
		clk_en <= 1'b0;
		wr(A_LCR, 8'h00);
		clk_en <= 1'b1;
		rd(A_LCR);
		chk(d, 8'h03);
		endt("transmit");
		for (int i = 0; i < 3; i++) put(8'($urandom), 1'b1);
		for (int i = 0; i < 3; i++) pop_chk();
		put(8'h5A, 1'b0);
		put(8'($urandom), 1'b1);
		rd(A_LSR);
		chk(d & 8'h1D, 8'h09);
		pop_chk();
		rd(A_LSR);
		chk(d & 8'h1C, 8'h00);
		pop_chk();
		i_ufc_remote.glitch(4);
		idle(200);
		rd(A_LSR);
		chk(d & 8'h01, 8'h00);
		endt("receive");
		wr(A_IER, 8'h01);
		put(8'($urandom), 1'b1);
		idle(400);
		rd(A_ISR);
		chk(d, ISR_RXRDY);
		idle(500);
		chk(8'(irq), 8'h01);
		rd(A_ISR);
		chk(d, ISR_TMO);
		pop_chk();
		rd(A_ISR);
		chk(d, ISR_NONE);
		endt("timeout");
		wr(A_EFR, 8'h50);
		wr(A_IER, 8'h40);
		wr(A_ISR, 8'h41);
		wr(A_MCR, 8'h02);
		for (int i = 0; i < 7; i++) put(8'($urandom), 1'b1);
		chk(8'(rts_n), 8'h00);
		put(8'($urandom), 1'b1);
		idle(4);
		chk(8'(rts_n), 8'h01);
		rd(A_ISR);
		chk(d, ISR_FLOW);
		fork
			put(8'($urandom), 1'b1);
		join_none
		for (int i = 0; i < 6; i++) pop_chk();
		chk(8'(rts_n), 8'h01);
		pop_chk();
		idle(3);
		chk(8'(rts_n), 8'h00);
		idle(220);
		pop_chk();
		pop_chk();
		endt("auto request");
		wr(A_EFR, 8'h90);
		wr(A_IER, 8'h80);
		cts_n <= 1'b1;
		idle(8);
		rd(A_ISR);
		chk(d, ISR_FLOW);
		sq.push_back(8'($urandom));
		wr(A_HOLD, sq[0]);
		idle(300);
		chk(8'(i_ufc_remote.got_q.size()), 8'h00);
		cts_n <= 1'b0;
		wait_q(1);
		chk(i_ufc_remote.got_q.pop_front(), sq.pop_front());
		endt("auto clear");
		wr(A_EFR, 8'h11);
		wr(A_XON1, 8'h11);
		wr(A_XOFF1, 8'h13);
		wr(A_IER, 8'h20);
		i_ufc_remote.send(8'h13, 1'b1);
		rd(A_ISR);
		chk(d, ISR_XOFF);
		rd(A_LSR);
		chk(d & 8'h01, 8'h00);
		sq.push_back(8'h3C);
		wr(A_HOLD, 8'h3C);
		idle(300);
		chk(8'(i_ufc_remote.got_q.size()), 8'h00);
		i_ufc_remote.send(8'h11, 1'b1);
		wait_q(1);
		chk(i_ufc_remote.got_q.pop_front(), sq.pop_front());
		rd(A_ISR);
		chk(d, ISR_NONE);
		endt("software flow");
		wr(A_EFR, 8'h14);
		for (int i = 0; i < 4; i++) put(8'($urandom), 1'b1);
		chk(8'(i_ufc_remote.got_q.size()), 8'h00);
		wait_q(1);
		chk(i_ufc_remote.got_q.pop_front(), 8'h13);
		for (int i = 0; i < 4; i++) pop_chk();
		wait_q(1);
		chk(i_ufc_remote.got_q.pop_front(), 8'h11);
		endt("xoff sending");
		close_out();
	end
endmodule
